/* File: verilog/see_eeprom.sv */
// Serial EEPROM command front end: pin sampling, opcode decode, status
// register, 128-byte array and page buffer FIFO.
// Assumes all pins are asynchronous to ref_clk and the serial clock is
// well below a quarter of ref_clk.
`timescale 1ns/1ps
`include "see_map.svh"

// Page buffer: flip-flop FIFO with valid and ready on both sides
module see_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = `SEE_PAGE_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Discard all entries
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH]; // Entry storage
  logic [PW-1:0] rd_ff, nxt_rd; // Read index
  logic [PW-1:0] wr_ff, nxt_wr; // Write index
  logic [PW:0] cnt_ff, nxt_cnt; // Fill level
  logic push;
  logic pop;

  // A full buffer still takes a word when one leaves in the same cycle
  assign out_valid = (cnt_ff != '0);
  assign in_ready = (cnt_ff != (PW+1)'(DEPTH)) || out_ready;
  assign out_data = mem_ff[rd_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and level update
  always_comb begin
    nxt_rd = rd_ff;
    nxt_wr = wr_ff;
    nxt_cnt = cnt_ff;
    if (flush) begin
      nxt_rd = '0;
      nxt_wr = '0;
      nxt_cnt = '0;
    end else begin
      if (push) begin
        nxt_wr = (wr_ff == PW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        nxt_rd = (rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      end
      nxt_cnt = cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_ff <= '0;
      wr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage needs no reset, nothing is read before written
  always_ff @(posedge ref_clk) begin
    if (push && !flush) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule : see_fifo

// Device top
module see_eeprom
  import see_pkg::*;
#(
  parameter int WRITE_CYCLES = `SEE_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Serial link pins
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // Control pins
  input wire logic write_protect_n,
  input wire logic pause_n,
  // Power state
  output logic standby
);
  // Pin synchronisers: cs, sck, si, wp, pause
  logic [4:0] sync1_ff, sync2_ff;
  logic sck_d_ff; // Previous synced clock, for edges
  logic cs_d_ff; // Previous synced select
  logic cs_q, sck_q, si_q, wp_q, pause_q;
  logic sel, rise, fall, cs_rise, cs_fall;

  // Transfer state
  see_state_t state_ff, nxt_state;
  logic [2:0] bitpos_ff, nxt_bitpos; // Bits taken in current byte
  logic [7:0] shin_ff, nxt_shin; // Input shift register
  logic [7:0] out_sr_ff, nxt_out_sr; // Output shift register
  logic [2:0] out_cnt_ff, nxt_out_cnt; // Bits sent in current byte
  logic so_ff, nxt_so; // Output pin value
  logic [`SEE_ADDR_W-1:0] addr_ff, nxt_addr; // Read or write address
  // Status and write engine
  logic wel_ff, nxt_wel;
  logic [1:0] ps_ff, nxt_ps; // Protect size
  logic [1:0] ps_pend_ff, nxt_ps_pend; // Protect size being written
  logic busy_ff, nxt_busy;
  logic is_stat_ff, nxt_is_stat; // Current write targets status
  logic [31:0] busy_cnt_ff, nxt_busy_cnt;
  // Array
  logic [7:0] mem_ff [`SEE_MEM_WORDS];
  logic mem_we;
  logic [`SEE_ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  // Page buffer
  see_wr_t fifo_in, fifo_out;
  logic fifo_push, fifo_in_ready, fifo_valid, fifo_pop, fifo_flush;
  see_status_t status;
  logic [7:0] byte_in; // Byte completed by this rising edge
  logic [`SEE_ADDR_W-1:0] next_rd;

  // Region shielded by protect size
  function automatic logic is_protected(input logic [`SEE_ADDR_W-1:0] a,
                                        input logic [1:0] ps);
    logic r;
    r = 1'b0;
    unique case (ps)
      `SEE_PS_NONE: r = 1'b0;
      `SEE_PS_QUARTER: r = (a[`SEE_ADDR_W-1 -: 2] == 2'h3);
      `SEE_PS_HALF: r = a[`SEE_ADDR_W-1];
      `SEE_PS_ALL: r = 1'b1;
    endcase
    return r;
  endfunction : is_protected

  // Synchroniser registers; first stage feeds only the second
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= 5'h1d;
      sync2_ff <= 5'h1d;
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
    end else begin
      sync1_ff <= {pause_n, write_protect_n, serial_in, serial_clock,
                   chip_select_n};
      sync2_ff <= sync1_ff;
      sck_d_ff <= sync2_ff[1];
      cs_d_ff <= sync2_ff[0];
    end
  end

  assign cs_q = sync2_ff[0];
  assign sck_q = sync2_ff[1];
  assign si_q = sync2_ff[2];
  assign wp_q = sync2_ff[3];
  assign pause_q = sync2_ff[4];
  assign sel = !cs_q;
  // Clock edges are ignored while paused; the last level is still tracked
  assign rise = sel && pause_q && sck_q && !sck_d_ff;
  assign fall = sel && pause_q && !sck_q && sck_d_ff;
  assign cs_rise = cs_q && !cs_d_ff;
  assign cs_fall = sel && cs_d_ff;
  assign byte_in = {shin_ff[6:0], si_q};
  assign next_rd = addr_ff + 1'b1;

  // Status as seen by a read
  always_comb begin
    status.fill = `SEE_STAT_FILL;
    status.protect_size = ps_ff;
    status.write_enable_latch = wel_ff;
    status.write_busy_flag = busy_ff;
  end

  // Page buffer; a full buffer drops its oldest byte to let a wrapped
  // byte overwrite the one sixteen places back
  see_fifo #(
    .WIDTH($bits(see_wr_t)),
    .DEPTH(`SEE_PAGE_DEPTH)
  ) u_page (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .flush(fifo_flush),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  // Transfer and write engine next state
  always_comb begin
    nxt_state = state_ff;
    nxt_bitpos = bitpos_ff;
    nxt_shin = shin_ff;
    nxt_out_sr = out_sr_ff;
    nxt_out_cnt = out_cnt_ff;
    nxt_so = so_ff;
    nxt_addr = addr_ff;
    nxt_wel = wel_ff;
    nxt_ps = ps_ff;
    nxt_ps_pend = ps_pend_ff;
    nxt_busy = busy_ff;
    nxt_is_stat = is_stat_ff;
    nxt_busy_cnt = busy_cnt_ff;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    fifo_flush = 1'b0;
    fifo_in.addr = addr_ff;
    fifo_in.data = byte_in;
    mem_we = 1'b0;
    mem_wa = fifo_out.addr;
    mem_wd = fifo_out.data;
    if (cs_q) begin
      // Deselected: commit only exact frames, then drop the transfer
      nxt_state = SEE_IDLE;
      nxt_bitpos = 3'h0;
      nxt_out_cnt = 3'h0;
      if (cs_rise) begin
        unique case (state_ff)
          SEE_SET_END: nxt_wel = 1'b1;
          SEE_CLR_END: nxt_wel = 1'b0;
          SEE_STAT_END: begin
            if (wel_ff && wp_q && !busy_ff) begin
              nxt_ps_pend = shin_ff[`SEE_STAT_PS_HI:`SEE_STAT_PS_LO];
              nxt_busy = 1'b1;
              nxt_is_stat = 1'b1;
              nxt_busy_cnt = '0;
            end
          end
          SEE_WR_DATA: begin
            // Needs whole bytes, the latch, the pin and an open region
            if (bitpos_ff == 3'h0 && fifo_valid && wel_ff && wp_q &&
                !busy_ff && !is_protected(fifo_out.addr, ps_ff)) begin
              nxt_busy = 1'b1;
              nxt_is_stat = 1'b0;
              nxt_busy_cnt = '0;
            end else begin
              fifo_flush = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end else if (cs_fall) begin
      // Fresh select fall starts a command
      nxt_state = SEE_OPCODE;
      nxt_bitpos = 3'h0;
      nxt_out_cnt = 3'h0;
    end else if (rise) begin
      nxt_shin = byte_in;
      nxt_bitpos = bitpos_ff + 1'b1;
      unique case (state_ff)
        SEE_OPCODE: begin
          if (bitpos_ff == 3'h7) begin
            if (byte_in[7:4] != `SEE_OP_HI_ZERO) begin
              nxt_state = SEE_IGNORE;
            end else begin
              // Bit 3 is not examined
              unique case (byte_in[2:0])
                `SEE_OP_SET_WEL: nxt_state = SEE_SET_END;
                `SEE_OP_CLR_WEL: nxt_state = SEE_CLR_END;
                `SEE_OP_RD_STAT: begin
                  nxt_state = SEE_STAT_OUT;
                  nxt_out_sr = status;
                  nxt_out_cnt = 3'h0;
                end
                `SEE_OP_WR_STAT: nxt_state = SEE_STAT_IN;
                // Array reads and writes are not taken while busy
                `SEE_OP_RD_MEM: nxt_state = busy_ff ? SEE_IGNORE : SEE_ADDR_RD;
                `SEE_OP_WR_MEM: nxt_state = busy_ff ? SEE_IGNORE : SEE_ADDR_WR;
                default: nxt_state = SEE_IGNORE;
              endcase
            end
          end
        end
        SEE_ADDR_RD: begin
          if (bitpos_ff == 3'h7) begin
            nxt_addr = byte_in[`SEE_ADDR_W-1:0];
            nxt_out_sr = mem_ff[byte_in[`SEE_ADDR_W-1:0]];
            nxt_out_cnt = 3'h0;
            nxt_state = SEE_MEM_OUT;
          end
        end
        SEE_ADDR_WR: begin
          if (bitpos_ff == 3'h7) begin
            nxt_addr = byte_in[`SEE_ADDR_W-1:0];
            nxt_state = SEE_WR_DATA;
          end
        end
        SEE_STAT_IN: begin
          if (bitpos_ff == 3'h7) begin
            nxt_state = SEE_STAT_END;
          end
        end
        SEE_WR_DATA: begin
          if (bitpos_ff == 3'h7) begin
            fifo_push = 1'b1;
            // Head entry at this very address means the page has wrapped;
            // decided from the head alone so no loop runs through ready
            fifo_pop = fifo_valid && (fifo_out.addr == addr_ff);
            // Only the page offset advances
            nxt_addr[`SEE_PAGE_BITS-1:0] = addr_ff[`SEE_PAGE_BITS-1:0] + 1'b1;
          end
        end
        // One clock too many cancels the pending command
        SEE_SET_END, SEE_CLR_END, SEE_STAT_END: nxt_state = SEE_IGNORE;
        default: begin
        end
      endcase
    end else if (fall) begin
      if (state_ff == SEE_STAT_OUT || state_ff == SEE_MEM_OUT) begin
        nxt_so = out_sr_ff[7];
        nxt_out_cnt = out_cnt_ff + 1'b1;
        if (out_cnt_ff == 3'h7) begin
          if (state_ff == SEE_STAT_OUT) begin
            nxt_out_sr = status;
          end else begin
            nxt_addr = next_rd;
            nxt_out_sr = mem_ff[next_rd];
          end
        end else begin
          nxt_out_sr = {out_sr_ff[6:0], 1'b0};
        end
      end
    end
    // Internal write cycle runs regardless of the pins
    if (busy_ff) begin
      nxt_busy_cnt = busy_cnt_ff + 32'h1;
      if (!is_stat_ff && fifo_valid) begin
        fifo_pop = 1'b1;
        mem_we = !is_protected(fifo_out.addr, ps_ff);
      end
      if (busy_cnt_ff == 32'(WRITE_CYCLES - 1)) begin
        nxt_busy = 1'b0;
        // A set command landing in the same cycle wins over the clear
        if (!(cs_rise && state_ff == SEE_SET_END)) begin
          nxt_wel = 1'b0;
        end
        if (is_stat_ff) begin
          nxt_ps = ps_pend_ff;
        end
      end
    end
    // Protect pin low holds the latch clear
    if (!wp_q) begin
      nxt_wel = 1'b0;
    end
  end

  // Transfer and write engine registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= SEE_IDLE;
      bitpos_ff <= 3'h0;
      shin_ff <= 8'h00;
      out_sr_ff <= 8'h00;
      out_cnt_ff <= 3'h0;
      so_ff <= 1'b0;
      addr_ff <= '0;
      wel_ff <= 1'b0;
      ps_ff <= `SEE_PS_RESET;
      ps_pend_ff <= `SEE_PS_RESET;
      busy_ff <= 1'b0;
      is_stat_ff <= 1'b0;
      busy_cnt_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      bitpos_ff <= nxt_bitpos;
      shin_ff <= nxt_shin;
      out_sr_ff <= nxt_out_sr;
      out_cnt_ff <= nxt_out_cnt;
      so_ff <= nxt_so;
      addr_ff <= nxt_addr;
      wel_ff <= nxt_wel;
      ps_ff <= nxt_ps;
      ps_pend_ff <= nxt_ps_pend;
      busy_ff <= nxt_busy;
      is_stat_ff <= nxt_is_stat;
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end

  // Array storage; reset stands in for the erased state
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `SEE_MEM_WORDS; i++) begin
        mem_ff[i] <= `SEE_MEM_RESET;
      end
    end else if (mem_we) begin
      mem_ff[mem_wa] <= mem_wd;
    end
  end

  // Output enable only in read phases, selected and not paused
  assign serial_out_oe = sel && pause_q &&
                         (state_ff == SEE_STAT_OUT || state_ff == SEE_MEM_OUT);
  assign serial_out = so_ff;
  assign standby = cs_q && !busy_ff;
endmodule : see_eeprom

/* File: verilog/see_map.svh */
// Constants of the serial EEPROM command front end.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SEE_MAP_SVH
`define SEE_MAP_SVH
// Array geometry (smallest variant, 128 bytes)
`define SEE_ADDR_W 7
`define SEE_MEM_WORDS 128
`define SEE_PAGE_DEPTH 16
`define SEE_PAGE_BITS 4
// Opcode fields: upper nibble must be zero, bit 3 is ignored
`define SEE_OP_HI_ZERO 4'h0
`define SEE_OP_SET_WEL 3'h6
`define SEE_OP_CLR_WEL 3'h4
`define SEE_OP_RD_STAT 3'h5
`define SEE_OP_WR_STAT 3'h1
`define SEE_OP_RD_MEM 3'h3
`define SEE_OP_WR_MEM 3'h2
// Status register layout
`define SEE_STAT_FILL 4'hf
`define SEE_STAT_PS_HI 3
`define SEE_STAT_PS_LO 2
`define SEE_STAT_WEL 1
`define SEE_STAT_BUSY 0
// Reset values
`define SEE_PS_RESET 2'h0
`define SEE_MEM_RESET 8'hff
// Protect-size encodings
`define SEE_PS_NONE 2'h0
`define SEE_PS_QUARTER 2'h1
`define SEE_PS_HALF 2'h2
`define SEE_PS_ALL 2'h3
// Internal nonvolatile write time in ref_clk cycles
`define SEE_WRITE_CYCLES 1000
`endif

/* File: verilog/see_pkg.sv */
// Types shared by the serial EEPROM command front end.
// Assumes the constants header is on the include path.
`include "see_map.svh"
package see_pkg;
  // Transfer phases of one selected frame
  typedef enum logic [3:0] {
    SEE_IDLE, SEE_OPCODE, SEE_SET_END, SEE_CLR_END, SEE_STAT_OUT,
    SEE_STAT_IN, SEE_STAT_END, SEE_ADDR_RD, SEE_ADDR_WR, SEE_MEM_OUT,
    SEE_WR_DATA, SEE_IGNORE
  } see_state_t;
  // One buffered page byte with its target address
  typedef struct packed {
    logic [`SEE_ADDR_W-1:0] addr;
    logic [7:0] data;
  } see_wr_t;
  // Status byte as read out
  typedef struct packed {
    logic [3:0] fill;
    logic [1:0] protect_size;
    logic write_enable_latch;
    logic write_busy_flag;
  } see_status_t;
endpackage : see_pkg

/* File: testbench/see_monitor.sv */
// Checker: pin timing relations of the serial EEPROM front end.
// Assumes it is bound to see_eeprom and sees only its ports.
`timescale 1ns/1ps
module see_monitor
  import see_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Link and control pins
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic pause_n,
  input wire logic standby
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Last clock sample and cycles since its last fall and rise
  logic sck_ff;
  logic [3:0] fall_ff;
  logic [3:0] rise_ff;
  logic [3:0] nxt_fall;
  logic [3:0] nxt_rise;
  // Ages saturate so a long idle link never wraps into the window
  always_comb begin
    nxt_fall = (fall_ff == 4'hf) ? fall_ff : fall_ff + 4'h1;
    nxt_rise = (rise_ff == 4'hf) ? rise_ff : rise_ff + 4'h1;
    if (sck_ff && !serial_clock) begin
      nxt_fall = 4'h0;
    end
    if (!sck_ff && serial_clock) begin
      nxt_rise = 4'h0;
    end
  end
  // Registers only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sck_ff <= 1'b0;
      fall_ff <= 4'hf;
      rise_ff <= 4'hf;
    end else begin
      sck_ff <= serial_clock;
      fall_ff <= nxt_fall;
      rise_ff <= nxt_rise;
    end
  end
  // Pin held long enough to pass the synchronisers
  sequence s_desel;
    chip_select_n [*5];
  endsequence
  sequence s_paused;
    !pause_n [*5];
  endsequence
  a_desel_float: assert property (s_desel |-> !serial_out_oe)
    else $error("output driven while deselected");
  a_pause_float: assert property (s_paused |-> !serial_out_oe)
    else $error("output driven while paused");
  a_fall_to_out: assert property (serial_out_oe && $changed(serial_out) |->
    fall_ff inside {[4'h1:4'h5]}) else $error("output moved away from a clock fall");
  a_high_stable: assert property (serial_out_oe && serial_clock && $past(serial_clock)
    |-> $stable(serial_out)) else $error("output moved while clock high");
  a_rise_to_oe: assert property ($rose(serial_out_oe) && $past(pause_n, 6) |->
    rise_ff inside {[4'h1:4'h5]}) else $error("output phase began off a clock rise");
  a_oe_active: assert property (serial_out_oe |-> !standby)
    else $error("output driven in standby");
  a_oe_holds: assert property (serial_out_oe && !chip_select_n && pause_n |=>
    serial_out_oe) else $error("output phase ended while selected");
  a_select_quiet: assert property ($fell(chip_select_n) |-> !serial_out_oe [*3])
    else $error("output driven at frame start");
  a_wake_up: assert property ($fell(chip_select_n) |-> ##[1:4] !standby)
    else $error("no wake from standby on select");
endmodule : see_monitor
bind see_eeprom see_monitor u_mon (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .chip_select_n(chip_select_n),
  .serial_clock(serial_clock),
  .serial_out(serial_out),
  .serial_out_oe(serial_out_oe),
  .pause_n(pause_n),
  .standby(standby)
);

/* File: testbench/see_host_model.sv */
// SPI host model, mode 0, serial clock of sixteen ref_clk cycles.
// Assumes ref_clk at 100 MHz; pins move 1 ns after its rising edge.
`timescale 1ns/1ps
module see_host_model (
  // Clock
  input wire logic ref_clk,
  // Device outputs
  input wire logic serial_out,
  input wire logic serial_out_oe,
  // Host pins
  output logic chip_select_n,
  output logic serial_clock,
  output logic serial_in,
  output logic pause_n,
  // Device drove its output during the last frame
  output logic oe_any
);
  // A floating line shows a pattern that flips every cycle
  logic tgl_ff;
  logic so_line;
  assign so_line = serial_out_oe ? serial_out : tgl_ff;
  always @(posedge ref_clk) tgl_ff <= ~tgl_ff;
  // Idle pins at time zero
  initial begin
    tgl_ff = 1'b0;
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_in = 1'b0;
    pause_n = 1'b1;
    oe_any = 1'b0;
  end
  // Wait n edges, then step just past the edge
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  // One clock period; the line is taken at the rise
  task automatic pulse(output logic smp);
    step(8);
    serial_clock = 1'b1;
    smp = so_line;
    if (serial_out_oe === 1'b1) oe_any = 1'b1;
    step(8);
    serial_clock = 1'b0;
  endtask : pulse
  // One frame: bytes out MSB first, extra clocks, optional pause at a bit
  task automatic xfer(input logic [7:0] tx[$], input int extra, input int pause_at,
                      output logic [7:0] rx[$]);
    logic [7:0] b;
    logic d;
    rx = {};
    oe_any = 1'b0;
    step(1);
    chip_select_n = 1'b0;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        serial_in = tx[i][k];
        if (i * 8 + 7 - k == pause_at) begin
          // Let the last output update land before pausing
          step(6);
          pause_n = 1'b0;
          serial_in = ~serial_in;
          pulse(d);
          step(24);
          serial_in = tx[i][k];
          pause_n = 1'b1;
        end
        pulse(b[k]);
      end
      rx.push_back(b);
    end
    repeat (extra) pulse(d);
    step(8);
    chip_select_n = 1'b1;
    step(8);
  endtask : xfer
endmodule : see_host_model

/* File: testbench/tb_top.sv */
// Testbench: commands the EEPROM front end through the host model.
// Assumes the package, design, host model and checker compile with it.
`timescale 1ns/1ps
`define CHK(g, e) chk_val(8'(g), 8'(e));
module tb_top;
  localparam int WC = 600; // Shortened nonvolatile write time
  logic ref_clk;
  logic nrst;
  logic write_protect_n;
  logic chip_select_n;
  logic serial_clock;
  logic serial_in;
  logic pause_n;
  logic serial_out;
  logic serial_out_oe;
  logic standby;
  logic [7:0] rx[$];
  logic [7:0] bad[$];
  int n_errors = 0;
  int tests_run = 0;
  see_eeprom #(.WRITE_CYCLES(WC)) dut (.ref_clk(ref_clk), .nrst(nrst),
    .chip_select_n(chip_select_n), .serial_clock(serial_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .write_protect_n(write_protect_n), .pause_n(pause_n), .standby(standby));
  see_host_model host (.ref_clk(ref_clk), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .chip_select_n(chip_select_n),
    .serial_clock(serial_clock), .serial_in(serial_in), .pause_n(pause_n), .oe_any());
  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic conclude();
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // Frame of bytes with extra clocks
  task automatic run(input logic [7:0] tx[$], input int extra);
    host.xfer(tx, extra, -1, rx);
  endtask : run
  // Two status bytes; the second proves the byte repeats
  task automatic stat(input logic [7:0] exp);
    host.xfer('{8'h05, 8'h00, 8'h00}, 0, -1, rx);
    `CHK(rx[1], exp)
    `CHK(rx[2], exp)
  endtask : stat
  task automatic rdm(input logic [7:0] a, input logic [7:0] e[$]);
    logic [7:0] tx[$];
    tx = '{8'h03, a};
    foreach (e[i]) tx.push_back(8'h00);
    host.xfer(tx, 0, -1, rx);
    foreach (e[i]) `CHK(rx[i + 2], e[i])
  endtask : rdm
  task automatic wrm(input logic [7:0] a, input logic [7:0] d[$]);
    logic [7:0] tx[$];
    tx = d;
    tx.push_front(a);
    tx.push_front(8'h02);
    host.xfer(tx, 0, -1, rx);
  endtask : wrm
  // Busy time is fixed by the parameter
  task automatic settle();
    repeat (WC + 20) @(posedge ref_clk);
    #1;
  endtask : settle
  // Hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end
  initial begin
    nrst = 1'b0;
    write_protect_n = 1'b1;
    repeat (12) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    host.step(4);
    `CHK(standby, 1'b1)
    `CHK(serial_out_oe, 1'b0)
    stat(8'hf0);
    run('{8'h06}, 0);
    stat(8'hf2);
    run('{8'h04}, 0);
    stat(8'hf0);
    run('{8'h06}, 1);
    stat(8'hf0);
    run('{8'h0e}, 0);
    stat(8'hf2);
    run('{8'h04}, 1);
    stat(8'hf2);
    run('{8'h84}, 0);
    bad = '{8'h07, 8'h15, 8'h8d, 8'h00};
    foreach (bad[i]) begin
      host.xfer('{bad[i], 8'h00, 8'h00}, 0, -1, rx);
      `CHK(host.oe_any, 1'b0)
    end
    stat(8'hf2);
    host.xfer('{8'h05, 8'h00, 8'h00}, 0, 10, rx);
    `CHK(rx[1], 8'hf2)
    wrm(8'h7e, '{8'ha1, 8'ha2, 8'ha3});
    `CHK(standby, 1'b0)
    stat(8'hf3);
    host.xfer('{8'h03, 8'h7e, 8'h00}, 0, -1, rx);
    `CHK(host.oe_any, 1'b0)
    settle();
    `CHK(standby, 1'b1)
    stat(8'hf0);
    rdm(8'hfe, '{8'ha1, 8'ha2, 8'hff});
    rdm(8'h70, '{8'ha3});
    wrm(8'h10, '{8'h55});
    settle();
    rdm(8'h10, '{8'hff});
    run('{8'h06}, 0);
    run('{8'h01, 8'h04}, 0);
    settle();
    stat(8'hf4);
    run('{8'h06}, 0);
    wrm(8'h60, '{8'h77});
    settle();
    rdm(8'h60, '{8'hff});
    run('{8'h06}, 0);
    wrm(8'h5f, '{8'h66});
    settle();
    rdm(8'h5f, '{8'h66});
    run('{8'h06}, 0);
    stat(8'hf6);
    write_protect_n = 1'b0;
    stat(8'hf4);
    rdm(8'h5f, '{8'h66});
    run('{8'h06}, 0);
    run('{8'h01, 8'h00}, 0);
    write_protect_n = 1'b1;
    settle();
    stat(8'hf4);
    conclude();
  end
endmodule : tb_top
